// ### rtl/pbcs_regs.sv
// Purpose: base control/status fields of a three-port serial bus PHY
// Assumes: all inputs synchronous to sys_clk; resetn is the hardware reset
// Notes:   bus reset is an input pulse from the PHY core
// Functional notes
// (RULE_01) Power class field copied to self-ID bits
// (RULE_02) Power class loaded from pins at reset
// (RULE_03) Resume start sets port event if enabled
// (RULE_04) Short reset request starts 1.3 us reset
// (RULE_05) Any bus reset clears short request
// (RULE_06) Tree-ID start timeout sets config flag
// (RULE_07) Cable power falling edge sets flag
// (RULE_08) State timeout sets state timeout flag
// (RULE_09) Non-loop timeout raises flag and reset
// (RULE_10) Flags clear on reset or write one
// (RULE_11) Enabled port status change sets event
// (RULE_12) Acceleration enable drives arbitration options
// (RULE_13) Link sets acceleration only if capable
// (RULE_14) Multispeed enable permits mixed-speed concatenation
// (RULE_15) Link enables multispeed only if compliant
// (RULE_16) Page selector, three bits, reset zero
// (RULE_17) Port selector, four bits, reset zero
// (RULE_18) Page zero shows selected port status
// (RULE_19) Writing zero leaves flags unchanged
module pbcs_regs
   import pbcs_pkg::*;
(
   input  wire logic                 sys_clk,
   input  wire logic                 resetn,
   input  wire pbcs_pkg::pbcs_req_t  req,
   output logic [7:0]                rdata,
   output logic                      irq,
   input  wire logic [2:0]           power_class_pins,
   input  wire logic                 cable_power_sense,
   input  wire logic                 bus_reset,
   input  wire logic                 config_timeout,
   input  wire logic                 state_timeout,
   input  wire logic                 arb_ready,
   input  wire pbcs_pkg::pbcs_port_t port_st [NUM_PORTS],
   output logic [2:0]                selfid_pwr,
   output logic                      short_reset_active,
   output logic                      bus_reset_req,
   output logic                      accel_arb_on,
   output logic                      flyby_on,
   output logic                      multispeed_on,
   output logic [NUM_PORTS-1:0]      port_disable
);
   import pbcs_pkg::*;

   logic [2:0]           node_power_class_reg;
   logic                 pwr_loaded_reg;
   logic                 resume_event_enable_reg;
   logic                 short_reset_request_reg;
   logic [3:0]           flags_reg;
   logic [3:0]           flags_next;
   logic [3:0]           mask_reg;
   logic                 accel_arbitration_enable_reg;
   logic                 multispeed_concat_enable_reg;
   logic [2:0]           page_selector_reg;
   logic [3:0]           port_selector_reg;
   logic [NUM_PORTS-1:0] per_port_event_enable_reg;
   logic [NUM_PORTS-1:0] dis_reg;
   logic [3:0]           port_snap_reg [NUM_PORTS];
   logic                 cps_d_reg;
   logic                 sto_reset_reg;
   pbcs_sr_t             sr_state_reg;
   logic [7:0]           sr_cnt_reg;
   logic [7:0]           rdata_reg;
   logic                 port_event;
   logic                 resume_event;
   logic                 port_ok;
   logic [1:0]           port_idx;
   logic [3:0]           set_vec;

   function automatic logic wr_hit(input pbcs_req_t r, input logic [3:0] a);
      return r.wr && (r.addr == a);
   endfunction

   assign port_ok  = (port_selector_reg < 4'(NUM_PORTS));
   assign port_idx = port_selector_reg[1:0];

   // Power class pins caught after reset release
   // (RULE_02) Load from pins
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         pwr_loaded_reg       <= 1'b0;
         node_power_class_reg <= 3'h0;
      end else if (!pwr_loaded_reg) begin
         pwr_loaded_reg       <= 1'b1;
         node_power_class_reg <= power_class_pins;
      end else if (wr_hit(req, ADDR_PWR)) begin
         node_power_class_reg <= req.wdata[2:0];
      end
   end

   // (RULE_01) Self-ID power field
   assign selfid_pwr = node_power_class_reg;

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         resume_event_enable_reg      <= 1'b0;
         accel_arbitration_enable_reg <= 1'b0;
         multispeed_concat_enable_reg <= 1'b0;
      end else if (wr_hit(req, ADDR_CTRL)) begin
         resume_event_enable_reg      <= req.wdata[B_RESUME];
         accel_arbitration_enable_reg <= req.wdata[B_ACCEL];
         multispeed_concat_enable_reg <= req.wdata[B_MSPD];
      end
   end

   // (RULE_12) Acceleration features
   assign accel_arb_on  = accel_arbitration_enable_reg;
   assign flyby_on      = accel_arbitration_enable_reg;
   // (RULE_14) Mixed-speed concatenation
   assign multispeed_on = multispeed_concat_enable_reg;

   // Selectors unaffected by bus reset
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         page_selector_reg <= PAGE_RST;
         port_selector_reg <= PORT_RST;
      end else if (wr_hit(req, ADDR_SEL)) begin
         // (RULE_16) Page select write
         page_selector_reg <= req.wdata[7:5];
         // (RULE_17) Port select write
         port_selector_reg <= req.wdata[3:0];
      end
   end

   // Per-port enable and disable bits, page zero
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         per_port_event_enable_reg <= '0;
         dis_reg                   <= '0;
      end else if (page_selector_reg == 3'h0 && port_ok) begin
         if (wr_hit(req, ADDR_PST0)) begin
            dis_reg[port_idx] <= req.wdata[B_DIS];
         end
         if (wr_hit(req, ADDR_PST1)) begin
            per_port_event_enable_reg[port_idx] <= req.wdata[B_PIE];
         end
      end
   end
   assign port_disable = dis_reg;

   // Port status change detection against a snapshot
   always_comb begin
      port_event   = 1'b0;
      resume_event = 1'b0;
      for (int i = 0; i < NUM_PORTS; i++) begin
         // (RULE_11) Enabled port change
         if (per_port_event_enable_reg[i] &&
             (port_snap_reg[i] != {port_st[i].con, port_st[i].bias, dis_reg[i],
                                   port_st[i].fault})) begin
            port_event = 1'b1;
         end
         // (RULE_03) Resume start event
         if (resume_event_enable_reg && port_st[i].resume_start) begin
            resume_event = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         for (int i = 0; i < NUM_PORTS; i++) begin
            port_snap_reg[i] <= 4'h0;
         end
         cps_d_reg <= 1'b1;
      end else begin
         for (int i = 0; i < NUM_PORTS; i++) begin
            port_snap_reg[i] <= {port_st[i].con, port_st[i].bias, dis_reg[i],
                                 port_st[i].fault};
         end
         cps_d_reg <= cable_power_sense;
      end
   end

   // Flag order: config timeout, cable power, state timeout, port event
   always_comb begin
      set_vec = 4'h0;
      // (RULE_06) Config timeout
      set_vec[3] = config_timeout;
      // (RULE_07) Falling cable power
      set_vec[2] = cps_d_reg && !cable_power_sense;
      // (RULE_08) State timeout
      set_vec[1] = state_timeout;
      set_vec[0] = port_event || resume_event;
      flags_next = flags_reg;
      if (wr_hit(req, ADDR_CTRL)) begin
         // (RULE_19) Zero bits keep flags
         flags_next = flags_reg & ~{req.wdata[B_CTO], req.wdata[B_CPD],
                                    req.wdata[B_STO], req.wdata[B_PEV]};
      end
      // Set wins over clear so no event is lost
      flags_next = flags_next | set_vec;
   end

   // (RULE_10) Hardware reset and write-one clear
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         flags_reg <= FLAG_RST;
      end else begin
         flags_reg <= flags_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         mask_reg <= 4'h0;
      end else if (wr_hit(req, ADDR_IMASK)) begin
         mask_reg <= req.wdata[3:0];
      end
   end
   assign irq = |(flags_reg & mask_reg);

   // (RULE_09) State timeout requests bus reset
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         sto_reset_reg <= 1'b0;
      end else begin
         sto_reset_reg <= state_timeout;
      end
   end
   assign bus_reset_req = sto_reset_reg;

   // Short reset request; bus reset clears it even on a same-cycle write
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         short_reset_request_reg <= 1'b0;
      // (RULE_05) Cleared by bus reset
      end else if (bus_reset) begin
         short_reset_request_reg <= 1'b0;
      end else if (wr_hit(req, ADDR_CTRL) && req.wdata[B_SHORT]) begin
         short_reset_request_reg <= 1'b1;
      end
   end

   // (RULE_04) Short reset sequencer
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         sr_state_reg <= SR_IDLE;
         sr_cnt_reg   <= 8'h00;
      end else begin
         case (sr_state_reg)
            SR_IDLE: begin
               if (short_reset_request_reg && !bus_reset) begin
                  sr_state_reg <= SR_WAIT;
               end
            end
            SR_WAIT: begin
               // Waits for arbitration win; traffic in progress completes first
               if (arb_ready) begin
                  sr_state_reg <= SR_RUN;
                  sr_cnt_reg   <= 8'(SHORT_RESET_CYC - 1);
               end
            end
            SR_RUN: begin
               if (sr_cnt_reg == 8'h00) begin
                  sr_state_reg <= SR_IDLE;
               end else begin
                  sr_cnt_reg <= sr_cnt_reg - 8'h01;
               end
            end
            default: sr_state_reg <= SR_IDLE;
         endcase
      end
   end
   assign short_reset_active = (sr_state_reg == SR_RUN);

   // Read data one cycle after strobe
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         rdata_reg <= 8'h00;
      end else if (req.rd) begin
         if (req.addr == ADDR_PWR) begin
            rdata_reg <= {5'h00, node_power_class_reg};
         end else if (req.addr == ADDR_CTRL) begin
            rdata_reg <= {resume_event_enable_reg, short_reset_request_reg, flags_reg,
                          accel_arbitration_enable_reg, multispeed_concat_enable_reg};
         end else if (req.addr == ADDR_SEL) begin
            rdata_reg <= {page_selector_reg, 1'b0, port_selector_reg};
         end else if (req.addr == ADDR_IMASK) begin
            rdata_reg <= {4'h0, mask_reg};
         // (RULE_18) Unimplemented port reads zero
         end else if (req.addr == ADDR_PST0 && page_selector_reg == 3'h0 && port_ok) begin
            rdata_reg <= {port_st[port_idx].astat, port_st[port_idx].bstat,
                          port_st[port_idx].child, port_st[port_idx].con,
                          port_st[port_idx].bias, dis_reg[port_idx]};
         end else if (req.addr == ADDR_PST1 && page_selector_reg == 3'h0 && port_ok) begin
            rdata_reg <= {1'b0, port_st[port_idx].peer_speed,
                          per_port_event_enable_reg[port_idx],
                          port_st[port_idx].fault, 2'h0};
         end else begin
            rdata_reg <= 8'h00;
         end
      end
   end
   assign rdata = rdata_reg;
endmodule

// ### pkg/pbcs_pkg.sv
// Purpose: constants and carriers for the base control/status register bank
// Assumes: 8-bit register data, 4-bit register address, 125 MHz clock
// Notes:   bit 0 of a register is the least significant data bit
package pbcs_pkg;
   localparam int unsigned CLK_MHZ = 125;
   // Short arbitrated reset length, nanoseconds
   localparam int unsigned SHORT_RESET_NS = 1300;
   localparam int unsigned SHORT_RESET_CYC = (SHORT_RESET_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned NUM_PORTS = 3;

   localparam logic [3:0] ADDR_PWR   = 4'h4;
   localparam logic [3:0] ADDR_CTRL  = 4'h5;
   localparam logic [3:0] ADDR_SEL   = 4'h7;
   localparam logic [3:0] ADDR_PST0  = 4'h8;
   localparam logic [3:0] ADDR_PST1  = 4'h9;
   localparam logic [3:0] ADDR_ISTAT = 4'ha;
   localparam logic [3:0] ADDR_IMASK = 4'hb;

   // Register 5 field positions (data bit index)
   localparam int unsigned B_RESUME = 7;
   localparam int unsigned B_SHORT  = 6;
   localparam int unsigned B_CTO    = 5;
   localparam int unsigned B_CPD    = 4;
   localparam int unsigned B_STO    = 3;
   localparam int unsigned B_PEV    = 2;
   localparam int unsigned B_ACCEL  = 1;
   localparam int unsigned B_MSPD   = 0;
   // Register 9 field
   localparam int unsigned B_PIE    = 4;
   // Register 8 fields
   localparam int unsigned B_CON    = 2;
   localparam int unsigned B_BIAS   = 1;
   localparam int unsigned B_DIS    = 0;
   localparam int unsigned B_FAULT  = 3;
   localparam logic [3:0] FLAG_RST  = 4'h0;
   localparam logic [2:0] PAGE_RST  = 3'h0;
   localparam logic [3:0] PORT_RST  = 4'h0;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } pbcs_req_t;

   typedef struct packed {
      logic [1:0] astat;
      logic [1:0] bstat;
      logic       child;
      logic       con;
      logic       bias;
      logic       fault;
      logic [2:0] peer_speed;
      logic       resume_start;
   } pbcs_port_t;

   typedef enum logic [1:0] {
      SR_IDLE = 2'b00,
      SR_WAIT = 2'b01,
      SR_RUN  = 2'b10
   } pbcs_sr_t;
endpackage

// ### verif/pbcs_regs_checker.sv
// Purpose: concurrent checks on the base control/status register bank
// Assumes: mask register low nibble enables cto, cpd, sto, pev
// Notes:   mask copy rebuilt from bus writes, as it is not a port
module pbcs_regs_checker
   import pbcs_pkg::*;
(
   input wire logic                sys_clk,
   input wire logic                resetn,
   input wire pbcs_pkg::pbcs_req_t req,
   input wire logic [7:0]          rdata,
   input wire logic                irq,
   input wire logic [2:0]          power_class_pins,
   input wire logic                cable_power_sense,
   input wire logic                bus_reset,
   input wire logic                config_timeout,
   input wire logic                state_timeout,
   input wire logic [2:0]          selfid_pwr,
   input wire logic                short_reset_active,
   input wire logic                bus_reset_req,
   input wire logic                accel_arb_on,
   input wire logic                flyby_on,
   input wire logic                multispeed_on
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] mask_reg;
   logic [8:0] run_reg;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   always_ff @(posedge sys_clk) begin
      if (!resetn) mask_reg <= 4'h0;
      else if (req.wr && req.addr == ADDR_IMASK) mask_reg <= req.wdata[3:0];
   end
   // Run length counter, cleared whenever short reset is not active (idle or waiting for arbitration)
   always_ff @(posedge sys_clk) begin
      if (!resetn || !short_reset_active) run_reg <= 9'h0;
      else run_reg <= run_reg + 9'h1;
   end
   a_pwr_readback: assert property ((req.rd && req.addr == ADDR_PWR) |=>
      rdata[2:0] == $past(selfid_pwr)) else $error("power class read mismatch");
   a_pwr_load: assert property ($rose(resetn) |-> ##2
      selfid_pwr == $past(power_class_pins, 2)) else $error("power class not loaded");
   a_cto_flag: assert property (config_timeout |=> irq || !mask_reg[3])
      else $error("config timeout flag not raised");
   a_cpd_flag: assert property ($fell(cable_power_sense) |=> irq || !mask_reg[2])
      else $error("cable power flag not raised");
   a_sto_busreset: assert property (state_timeout |=>
      bus_reset_req && (irq || !mask_reg[1])) else $error("state timeout not handled");
   a_short_len: assert property ($fell(short_reset_active) |->
      run_reg == SHORT_RESET_CYC) else $error("short reset length wrong");
   a_accel_write: assert property ((req.wr && req.addr == ADDR_CTRL) |=>
      accel_arb_on == $past(req.wdata[B_ACCEL]) && flyby_on == accel_arb_on)
      else $error("acceleration enable mismatch");
   a_mspd_write: assert property ((req.wr && req.addr == ADDR_CTRL) |=>
      multispeed_on == $past(req.wdata[B_MSPD])) else $error("multispeed enable mismatch");
   a_enable_keep: assert property ((bus_reset && !(req.wr && req.addr == ADDR_CTRL)) |=>
      $stable(accel_arb_on) && $stable(multispeed_on)) else $error("enable lost on bus reset");
endmodule

bind pbcs_regs pbcs_regs_checker chk_u (.sys_clk(sys_clk), .resetn(resetn), .req(req),
   .rdata(rdata), .irq(irq), .power_class_pins(power_class_pins),
   .cable_power_sense(cable_power_sense), .bus_reset(bus_reset),
   .config_timeout(config_timeout), .state_timeout(state_timeout), .selfid_pwr(selfid_pwr),
   .short_reset_active(short_reset_active), .bus_reset_req(bus_reset_req),
   .accel_arb_on(accel_arb_on), .flyby_on(flyby_on), .multispeed_on(multispeed_on));

// ### verif/pbcs_link_model.sv
// Purpose: link-layer controller model driving the register port
// Assumes: each task is entered just after a rising edge
// Notes:   a request stands one cycle; idle returns the port to rest
module pbcs_link_model
   import pbcs_pkg::*;
#(
   parameter bit COMPLIANT = 1'b1
)(
   input  wire logic           sys_clk,
   output pbcs_pkg::pbcs_req_t req
);
   timeunit 1ns;
   timeprecision 1ps;
   initial req = '0;
   task automatic op(input logic [3:0] a, input logic [7:0] d, input logic w);
      req <= '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge sys_clk);
   endtask
   task automatic idle();
      req <= '0;
      @(posedge sys_clk);
   endtask
   task automatic set_ctrl(input logic [7:0] d);
      op(ADDR_CTRL, COMPLIANT ? d : (d & 8'hfc), 1'b1);
   endtask
endmodule

// ### verif/phy_base_control_status_regs_tb.sv
// Purpose: self-checking bench for the base control/status registers
// Assumes: link model drives the bus; bench drives the PHY core inputs
// Notes:   reads are noted in a queue and compared by the monitor
module phy_base_control_status_regs_tb
   import pbcs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              sys_clk = 1'b0;
   logic              resetn = 1'b0;
   pbcs_req_t         req;
   logic [7:0]        rdata, en;
   logic [2:0]        power_class_pins = 3'h5, selfid_pwr;
   logic              irq, cable_power_sense, bus_reset, config_timeout, state_timeout;
   logic              arb_ready, short_reset_active, bus_reset_req, rd_seen = 1'b0;
   logic              accel_arb_on, flyby_on, multispeed_on;
   logic [NUM_PORTS-1:0] port_dis;
   pbcs_port_t        port_st [NUM_PORTS];
   logic [31:0]       seed = 32'ha78957dd, v;
   logic [7:0]        exp_q [$];
   int                fail_count = 0, tests_run = 0, i, n;

   pbcs_link_model #(.COMPLIANT(1'b1)) lm_u (.sys_clk(sys_clk), .req(req));
   pbcs_regs dut_u (.sys_clk(sys_clk), .resetn(resetn), .req(req), .rdata(rdata),
      .irq(irq), .power_class_pins(power_class_pins), .cable_power_sense(cable_power_sense),
      .bus_reset(bus_reset), .config_timeout(config_timeout), .state_timeout(state_timeout),
      .arb_ready(arb_ready), .port_st(port_st), .selfid_pwr(selfid_pwr),
      .short_reset_active(short_reset_active), .bus_reset_req(bus_reset_req),
      .accel_arb_on(accel_arb_on), .flyby_on(flyby_on), .multispeed_on(multispeed_on),
      .port_disable(port_dis));

   always #4 sys_clk = ~sys_clk;
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      lm_u.op(a, 8'h00, 1'b0);
   endtask
   task automatic brst();
      bus_reset <= 1'b1;
      lm_u.idle();
      bus_reset <= 1'b0;
   endtask
   // Events: 0 cfg timeout, 1 cable drop, 2 state timeout, 3 port 0 change
   task automatic ev(input int k);
      case (k)
         0: config_timeout <= 1'b1;
         1: cable_power_sense <= 1'b0;
         2: state_timeout <= 1'b1;
         default: port_st[0].con <= ~port_st[0].con;
      endcase
      lm_u.idle();
      config_timeout <= 1'b0;
      state_timeout <= 1'b0;
      cable_power_sense <= 1'b1;
      lm_u.idle();
   endtask
   task automatic irq_is(input logic e);
      @(negedge sys_clk);
      check({7'h0, irq}, {7'h0, e});
      @(posedge sys_clk);
   endtask

   // Read data are checked in the cycle after the read; rdata holds until the next read
   always @(posedge sys_clk) begin
      if (rd_seen) check(rdata, exp_q.pop_front());
      rd_seen <= req.rd;
   end
   initial begin
      repeat (5000) @(posedge sys_clk);
      fail_count++;
      test_done();
   end
   initial begin
      {config_timeout, state_timeout, bus_reset, arb_ready} = 4'h0;
      cable_power_sense = 1'b1;
      for (i = 0; i < NUM_PORTS; i++) begin
         v = rnd();
         port_st[i] = v[11:0] & 12'hffe;
      end
      repeat (10) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rd(ADDR_PWR, 8'h05);
      rd(ADDR_CTRL, 8'h00);
      rd(ADDR_SEL, 8'h00);
      v = rnd();
      en = v[15:8] & 8'h83;
      lm_u.op(ADDR_PWR, {5'h0, v[2:0]}, 1'b1);
      lm_u.set_ctrl(en);
      lm_u.op(ADDR_SEL, {v[7:5], 1'b0, v[3:0]}, 1'b1);
      brst();
      rd(ADDR_CTRL, en);
      rd(ADDR_SEL, {v[7:5], 1'b0, v[3:0]});
      rd(ADDR_PWR, {5'h0, v[2:0]});
      lm_u.op(ADDR_SEL, 8'h01, 1'b1);
      rd(ADDR_PST0, {port_st[1].astat, port_st[1].bstat, port_st[1].child, port_st[1].con,
         port_st[1].bias, 1'b0});
      lm_u.op(ADDR_SEL, 8'h05, 1'b1);
      rd(ADDR_PST0, 8'h00);
      lm_u.op(ADDR_SEL, 8'h20, 1'b1);
      rd(ADDR_PST0, 8'h00);
      lm_u.op(ADDR_SEL, 8'h00, 1'b1);
      lm_u.op(ADDR_PST1, 8'h10, 1'b1);
      lm_u.op(ADDR_ISTAT, 8'hff, 1'b1);
      rd(ADDR_ISTAT, 8'h00);
      lm_u.op(ADDR_IMASK, 8'h0f, 1'b1);
      rd(ADDR_IMASK, 8'h0f);
      for (i = 0; i < 4; i++) ev(i);
      rd(ADDR_CTRL, en | 8'h3c);
      lm_u.op(ADDR_IMASK, 8'h00, 1'b1);
      lm_u.idle();
      irq_is(1'b0);
      lm_u.op(ADDR_IMASK, 8'h0f, 1'b1);
      lm_u.idle();
      irq_is(1'b1);
      // Clearing one flag at a time shows the others survive
      for (i = 0; i < 4; i++) begin
         lm_u.set_ctrl(en | (8'h20 >> i));
         rd(ADDR_CTRL, en | ((8'h3c >> (i + 1)) & 8'h3c));
      end
      lm_u.idle();
      irq_is(1'b0);
      port_st[1].con <= ~port_st[1].con;
      lm_u.set_ctrl(en | 8'h80);
      lm_u.idle();
      rd(ADDR_CTRL, en | 8'h80);
      port_st[2].resume_start <= 1'b1;
      lm_u.idle();
      port_st[2].resume_start <= 1'b0;
      lm_u.idle();
      rd(ADDR_CTRL, en | 8'h84);
      en = en | 8'h80;
      lm_u.set_ctrl(en | 8'h44);
      rd(ADDR_CTRL, en | 8'h40);
      lm_u.idle();
      arb_ready <= 1'b1;
      n = 0;
      while (!short_reset_active && n < 20) begin
         @(posedge sys_clk);
         n++;
      end
      arb_ready <= 1'b0;
      n = 0;
      while (short_reset_active && n < 400) begin
         @(posedge sys_clk);
         n++;
      end
      check(8'(n), 8'(SHORT_RESET_CYC));
      brst();
      rd(ADDR_CTRL, en);
      // Disable on port 0 drives the pin and counts as a port event
      lm_u.op(ADDR_PST0, 8'h01, 1'b1);
      lm_u.idle();
      check({5'h0, port_dis}, 8'h01);
      rd(ADDR_CTRL, en | 8'h04);
      lm_u.idle();
      repeat (2) @(posedge sys_clk);
      test_done();
   end
endmodule
